// ===== rtl/cmpctl_top.sv
// Purpose: digital control around one analog comparator
// Assumes: synchronous inputs except cmp_raw; register read data one cycle late
// Notes:   timer clock source is sampled, its falling edge found in core_clk
// Summary of operation
// - positive channel code 00 pin, 01 converter ref, 10 fixed ref, 11 ground
// - enable clear disconnects every comparator input
// - negative select bit picks first or second negative pin
// - filter holds each output change from reversing for 20 ns
// - control 0 bit 3 enables filter, bypassed when clear, resets zero
// - control 0 bit 7 enables comparator, off draws no power, resets zero
// - control 0 bit 6 reads comparison result after polarity
// - control 0 bit 4 inverts output for every consumer
// - control 0 bit 5 drives pin when direction bit clear, independent of enable
// - control 0 bit 2 resets one for fast mode, clear for low power
// - control 0 bit 1 drives hysteresis enable to analog core
// - sync bit makes timer and pin output update on timer clock falls
// - control 1 bit 7 lets rising result edges set the flag
// - control 1 bit 6 lets falling result edges set the flag
// - result goes to waveform generator as shutdown and restart source
// - port read returns zero for every analog-selected pin
// - software clears the flag; a simultaneous edge keeps it set
// - edge detection runs while disabled, on post-polarity result
// - result sampled once per instruction cycle, mirrored read-only
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cmpctl_params.svh"
module cmpctl_top
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // register port
    input  wire logic [`CMPCTL_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [7:0]                      reg_rdata,
    // analog comparator core
    input  wire logic                       cmp_raw,
    output cmpctl_analog_s                  analog_ctrl,
    // digital consumers
    input  wire logic                       timer_clk_src,
    output cmpctl_consumer_s                consumer_out,
    // output pin and I/O port
    input  wire logic [`CMPCTL_PORT_W-1:0]  port_pins_in,
    output logic                            pin_out,
    output logic                            pin_oe,
    // interrupt flag toward the interrupt controller
    output logic                            cmp_irq_flag
);

    // register state
    logic [7:0]                 ctrl_main_reg;
    logic [7:0]                 ctrl_inputs_reg;
    logic [`CMPCTL_PORT_W-1:0]  analog_select_reg;
    logic [`CMPCTL_PORT_W-1:0]  pin_direction_reg;
    logic                       cmp_irq_flag_reg;
    logic                       cmp_irq_flag_next;
    logic [7:0]                 reg_rdata_reg;
    logic [7:0]                 reg_rdata_next;

    // named control fields
    logic       cmp_enable;
    logic       pin_drive_enable;
    logic       result_invert;
    logic       glitch_filter_enable;
    logic       speed_power_select;
    logic       hysteresis_enable;
    logic       timer_sync_enable;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic [1:0] positive_channel_select;
    logic       negative_channel_select;

    // result path
    logic       sync1_reg;
    logic       sync2_reg;
    logic       gated_result;
    logic       filtered_result;
    logic       polar_result;
    logic [1:0] instr_cnt_reg;
    logic       instr_tick;
    logic       cmp_result_reg;
    logic       cmp_result_prev_reg;
    logic       rise_edge;
    logic       fall_edge;
    logic       edge_hit;

    // timer-synchronous output
    logic       timer_clk_prev_reg;
    logic       timer_fall;
    logic       timer_synced_reg;
    logic       external_result;

    // register writes that clear the flag
    logic       flag_clear;

    assign cmp_enable              = ctrl_main_reg[`CMPCTL_MAIN_ENABLE];
    assign pin_drive_enable        = ctrl_main_reg[`CMPCTL_MAIN_PIN_DRIVE];
    assign result_invert           = ctrl_main_reg[`CMPCTL_MAIN_INVERT];
    assign glitch_filter_enable    = ctrl_main_reg[`CMPCTL_MAIN_FILTER];
    assign speed_power_select      = ctrl_main_reg[`CMPCTL_MAIN_SPEED];
    assign hysteresis_enable       = ctrl_main_reg[`CMPCTL_MAIN_HYST];
    assign timer_sync_enable       = ctrl_main_reg[`CMPCTL_MAIN_SYNC];
    assign rise_irq_enable         = ctrl_inputs_reg[`CMPCTL_IN_RISE_IRQ];
    assign fall_irq_enable         = ctrl_inputs_reg[`CMPCTL_IN_FALL_IRQ];
    assign positive_channel_select =
        ctrl_inputs_reg[`CMPCTL_IN_POS_HI:`CMPCTL_IN_POS_LO];
    assign negative_channel_select = ctrl_inputs_reg[`CMPCTL_IN_NEG];

    // ---- register writes ----

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // speed bit resets set, everything else clear
            ctrl_main_reg <= `CMPCTL_MAIN_RESET;
        end else if (reg_wr && reg_addr == `CMPCTL_ADDR_MAIN) begin
            // result bit is read-only, never stored
            ctrl_main_reg <= reg_wdata & `CMPCTL_MAIN_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_inputs_reg <= `CMPCTL_IN_RESET;
        end else if (reg_wr && reg_addr == `CMPCTL_ADDR_INPUTS_IRQ) begin
            // unimplemented bits 3..1 stay zero
            ctrl_inputs_reg <= reg_wdata & `CMPCTL_IN_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_select_reg <= `CMPCTL_ANALOG_RESET;
        end else if (reg_wr && reg_addr == `CMPCTL_ADDR_ANALOG_SEL) begin
            analog_select_reg <= reg_wdata[`CMPCTL_PORT_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_direction_reg <= `CMPCTL_PIN_DIR_RESET;
        end else if (reg_wr && reg_addr == `CMPCTL_ADDR_PIN_DIR) begin
            pin_direction_reg <= reg_wdata[`CMPCTL_PORT_W-1:0];
        end
    end

    // ---- analog core controls ----

    always_comb begin
        analog_ctrl                    = '0;
        // disabled core: no bias, no routes
        analog_ctrl.core_enable        = cmp_enable;
        analog_ctrl.speed_power_select = speed_power_select;
        analog_ctrl.hysteresis_enable  = hysteresis_enable;
        if (cmp_enable) begin
            case (positive_channel_select)
                `CMPCTL_POS_PIN:       analog_ctrl.pos_route = 4'h1;
                `CMPCTL_POS_CONV_REF:  analog_ctrl.pos_route = 4'h2;
                `CMPCTL_POS_FIXED_REF: analog_ctrl.pos_route = 4'h4;
                default:               analog_ctrl.pos_route = 4'h8;
            endcase
            analog_ctrl.neg_route = negative_channel_select ? 2'h2 : 2'h1;
        end else begin
            // every input switch opens while disabled
            analog_ctrl.pos_route = 4'h0;
            analog_ctrl.neg_route = 2'h0;
        end
    end

    // ---- result path ----

    // raw comparison is asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= cmp_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // a powered-down core reads low, polarity still applies after it
    assign gated_result = sync2_reg & cmp_enable;

    // filter after gating, so an idle core never starts a hold
    cmpctl_glitch_filter u_glitch_filter (
        .core_clk      (core_clk),
        .rst           (rst),
        .filter_enable (glitch_filter_enable),
        .din           (gated_result),
        .dout          (filtered_result)
    );

    assign polar_result = filtered_result ^ result_invert;

    // instruction cycle strobe for the software-visible latch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            instr_cnt_reg <= 2'h0;
        end else begin
            instr_cnt_reg <= instr_cnt_reg + 2'h1;
        end
    end

    assign instr_tick = (instr_cnt_reg == 2'(`CMPCTL_INSTR_CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_result_reg <= 1'b0;
        end else if (instr_tick) begin
            cmp_result_reg <= polar_result;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_result_prev_reg <= 1'b0;
        end else begin
            cmp_result_prev_reg <= cmp_result_reg;
        end
    end

    // edges seen even with the core off, so polarity or enable flips count
    assign rise_edge = cmp_result_reg & ~cmp_result_prev_reg;
    assign fall_edge = ~cmp_result_reg & cmp_result_prev_reg;
    assign edge_hit  = (rise_edge & rise_irq_enable)
                     | (fall_edge & fall_irq_enable);

    // ---- interrupt flag ----

    // writing zero to bit 0 of the flag register clears it
    assign flag_clear = reg_wr && reg_addr == `CMPCTL_ADDR_FLAG && !reg_wdata[0];

    always_comb begin
        cmp_irq_flag_next = cmp_irq_flag_reg;
        if (flag_clear) begin
            cmp_irq_flag_next = 1'b0;
        end
        // set beats clear so no edge is lost
        if (edge_hit) begin
            cmp_irq_flag_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_irq_flag_reg <= 1'b0;
        end else begin
            cmp_irq_flag_reg <= cmp_irq_flag_next;
        end
    end

    assign cmp_irq_flag = cmp_irq_flag_reg;

    // ---- timer-synchronous external output ----

    // previous sample against the live source, so the fall is acted on at the first edge that sees it low
    assign timer_fall = timer_clk_prev_reg & ~timer_clk_src;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_clk_prev_reg <= 1'b0;
        end else begin
            timer_clk_prev_reg <= timer_clk_src;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_synced_reg <= 1'b0;
        end else if (timer_fall) begin
            // latch on the fall so the timer, counting on rises, sees no race
            timer_synced_reg <= polar_result;
        end
    end

    // unsynchronised mode passes straight through, not latched
    assign external_result = timer_sync_enable ? timer_synced_reg : polar_result;

    always_comb begin
        consumer_out                   = '0;
        consumer_out.timer_gate        = external_result;
        consumer_out.waveform_shutdown = polar_result;
        consumer_out.result_mirror     = cmp_result_reg;
    end

    // ---- output pin ----

    // override holds even with the core off
    assign pin_oe  = pin_drive_enable & ~pin_direction_reg[`CMPCTL_OUT_PIN_BIT];
    assign pin_out = pin_oe & external_result;

    // ---- register reads ----

    always_comb begin
        reg_rdata_next = 8'h00;
        case (reg_addr)
            `CMPCTL_ADDR_MAIN: begin
                reg_rdata_next = ctrl_main_reg;
                reg_rdata_next[`CMPCTL_MAIN_RESULT] = cmp_result_reg;
            end
            `CMPCTL_ADDR_INPUTS_IRQ: begin
                reg_rdata_next = ctrl_inputs_reg;
            end
            `CMPCTL_ADDR_FLAG: begin
                reg_rdata_next = {7'h00, cmp_irq_flag_reg};
            end
            `CMPCTL_ADDR_MIRROR: begin
                reg_rdata_next = {7'h00, cmp_result_reg};
            end
            `CMPCTL_ADDR_PORT: begin
                // analog pins read zero whatever their voltage
                reg_rdata_next = {2'h0, port_pins_in & ~analog_select_reg};
            end
            `CMPCTL_ADDR_ANALOG_SEL: begin
                reg_rdata_next = {2'h0, analog_select_reg};
            end
            `CMPCTL_ADDR_PIN_DIR: begin
                reg_rdata_next = {2'h0, pin_direction_reg};
            end
            default: begin
                reg_rdata_next = 8'h00;
            end
        endcase
    end

    // data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= reg_rdata_next;
        end else begin
            reg_rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_reg;

endmodule

// ===== rtl/cmpctl_params.svh
// Purpose: constants for the comparator control block
// Assumes: 100 MHz core_clk, one comparator, 6-bit I/O port
// Notes:   offsets are register indices on the plain register port
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// register map
`define CMPCTL_ADDR_W           4
`define CMPCTL_ADDR_MAIN        4'h0
`define CMPCTL_ADDR_INPUTS_IRQ  4'h1
`define CMPCTL_ADDR_FLAG        4'h2
`define CMPCTL_ADDR_MIRROR      4'h3
`define CMPCTL_ADDR_PORT        4'h4
`define CMPCTL_ADDR_ANALOG_SEL  4'h5
`define CMPCTL_ADDR_PIN_DIR     4'h6

// control register 0 fields
`define CMPCTL_MAIN_ENABLE      7
`define CMPCTL_MAIN_RESULT      6
`define CMPCTL_MAIN_PIN_DRIVE   5
`define CMPCTL_MAIN_INVERT      4
`define CMPCTL_MAIN_FILTER      3
`define CMPCTL_MAIN_SPEED       2
`define CMPCTL_MAIN_HYST        1
`define CMPCTL_MAIN_SYNC        0
`define CMPCTL_MAIN_WMASK       8'hbf
`define CMPCTL_MAIN_RESET       8'h04

// control register 1 fields
`define CMPCTL_IN_RISE_IRQ      7
`define CMPCTL_IN_FALL_IRQ      6
`define CMPCTL_IN_POS_HI        5
`define CMPCTL_IN_POS_LO        4
`define CMPCTL_IN_NEG           0
`define CMPCTL_IN_WMASK         8'hf1
`define CMPCTL_IN_RESET         8'h00

// positive channel codes
`define CMPCTL_POS_PIN          2'h0
`define CMPCTL_POS_CONV_REF     2'h1
`define CMPCTL_POS_FIXED_REF    2'h2
`define CMPCTL_POS_GROUND       2'h3

// port side
`define CMPCTL_PORT_W           6
`define CMPCTL_OUT_PIN_BIT      2
`define CMPCTL_ANALOG_RESET     6'h00
`define CMPCTL_PIN_DIR_RESET    6'h3f

// timing
`define CMPCTL_CLK_PERIOD_PS    10000
`define CMPCTL_FILTER_HOLD_NS   20
`define CMPCTL_FILTER_HOLD_CYC  ((`CMPCTL_FILTER_HOLD_NS * 1000 + `CMPCTL_CLK_PERIOD_PS - 1) / `CMPCTL_CLK_PERIOD_PS)
`define CMPCTL_CNT_W            4
`define CMPCTL_INSTR_CYCLES     4

`endif

// ===== rtl/cmpctl_pkg.sv
// Purpose: types shared by the comparator control files
// Assumes: constants live in cmpctl_params.svh
// Notes:   the analog bundle goes straight to the comparator core
package cmpctl_pkg;

    // controls toward the analog core and its input muxes
    typedef struct packed {
        logic       core_enable;
        logic       speed_power_select;
        logic       hysteresis_enable;
        logic [3:0] pos_route;
        logic [1:0] neg_route;
    } cmpctl_analog_s;

    // outputs toward other digital consumers
    typedef struct packed {
        logic timer_gate;
        logic waveform_shutdown;
        logic result_mirror;
    } cmpctl_consumer_s;

    typedef enum logic [0:0] {
        FLT_PASS,
        FLT_HOLD
    } cmpctl_filter_state_e;

endpackage

// ===== rtl/cmpctl_glitch_filter.sv
// Purpose: zero latency anti-oscillation filter
// Assumes: din is already synchronous to core_clk
// Notes:   first change passes at once, reversal is blocked for the hold time
`timescale 1ns/1ps
`include "cmpctl_params.svh"
module cmpctl_glitch_filter
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // control
    input  wire logic filter_enable,
    // data
    input  wire logic din,
    output logic      dout
);

    localparam logic [`CMPCTL_CNT_W-1:0] HOLD_CYC =
        `CMPCTL_CNT_W'(`CMPCTL_FILTER_HOLD_CYC);

    cmpctl_filter_state_e            state_reg;
    logic                            held_reg;
    logic [`CMPCTL_CNT_W-1:0]        cnt_reg;

    // no latency: outside the hold the input shows directly
    assign dout = (filter_enable && state_reg == FLT_HOLD) ? held_reg : din;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= FLT_PASS;
            held_reg  <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                FLT_PASS: begin
                    held_reg <= din;
                    if (filter_enable && din != held_reg) begin
                        state_reg <= FLT_HOLD;
                        cnt_reg   <= HOLD_CYC - `CMPCTL_CNT_W'(1);
                    end
                end
                FLT_HOLD: begin
                    if (cnt_reg == '0 || !filter_enable) begin
                        state_reg <= FLT_PASS;
                    end else begin
                        cnt_reg <= cnt_reg - `CMPCTL_CNT_W'(1);
                    end
                end
                default: state_reg <= FLT_PASS;
            endcase
        end
    end

endmodule

// ===== tb/cmpctl_core_model.sv
// Purpose: behavioural comparator core with its input muxes
// Assumes: levels are unsigned codes picked by the one-hot routes
// Notes:   output is meaningless with inputs cut off, so it toggles
`timescale 1ns/1ps
module cmpctl_core_model
    import cmpctl_pkg::*;
(
    // clock
    input  wire logic           core_clk,
    // controls
    input  wire cmpctl_analog_s analog_ctrl,
    input  wire logic           slow,
    // analog levels
    input  wire logic [7:0]     v_pin,
    input  wire logic [7:0]     v_dac,
    input  wire logic [7:0]     v_fvr,
    input  wire logic [7:0]     v_n0,
    input  wire logic [7:0]     v_n1,
    // comparison
    output logic                cmp_raw
);
    logic [7:0] vp;
    logic [7:0] vn;
    logic [1:0] div_reg = 2'h0;

    initial cmp_raw = 1'b0;

    always_comb begin
        case (analog_ctrl.pos_route)
            4'h1: vp = v_pin;
            4'h2: vp = v_dac;
            4'h4: vp = v_fvr;
            default: vp = 8'h00;
        endcase
        vn = analog_ctrl.neg_route[1] ? v_n1 : v_n0;
    end

    // slow mode answers only every third cycle
    always @(posedge core_clk) begin
        div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
        if (analog_ctrl.pos_route == 4'h0 || analog_ctrl.neg_route == 2'h0) begin
            cmp_raw <= ~cmp_raw;
        end else if (!slow || div_reg == 2'h0) begin
            cmp_raw <= vp > vn;
        end
    end
endmodule

// ===== tb/cmpctl_checker_sva.sv
// Purpose: port-level checks of the comparator control block
// Assumes: register writes shadowed here from the register port
// Notes:   result path checks need a stable control register
`timescale 1ns/1ps
`include "cmpctl_params.svh"
module cmpctl_checker
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // register port
    input  wire logic [`CMPCTL_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    // block inputs and outputs
    input  wire logic                      cmp_raw,
    input  wire cmpctl_analog_s            analog_ctrl,
    input  wire logic                      timer_clk_src,
    input  wire cmpctl_consumer_s          consumer_out,
    input  wire logic                      pin_oe,
    input  wire logic                      cmp_irq_flag
);
    logic [7:0] main_sh;
    logic [7:0] inp_sh;
    logic       dir2_sh;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_sh <= `CMPCTL_MAIN_RESET;
            inp_sh  <= `CMPCTL_IN_RESET;
            dir2_sh <= 1'b1;
        end else if (reg_wr) begin
            if (reg_addr == `CMPCTL_ADDR_MAIN) main_sh <= reg_wdata & `CMPCTL_MAIN_WMASK;
            if (reg_addr == `CMPCTL_ADDR_INPUTS_IRQ) inp_sh <= reg_wdata & `CMPCTL_IN_WMASK;
            if (reg_addr == `CMPCTL_ADDR_PIN_DIR) dir2_sh <= reg_wdata[2];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    route_off_a: assert property (
        !analog_ctrl.core_enable |-> analog_ctrl.pos_route == 4'h0 && analog_ctrl.neg_route == 2'h0)
        else $error("inputs routed while disabled");
    pos_route_a: assert property (
        analog_ctrl.core_enable |-> analog_ctrl.pos_route == (4'h1 << inp_sh[5:4]))
        else $error("positive route wrong");
    neg_route_a: assert property (
        analog_ctrl.core_enable |-> analog_ctrl.neg_route == (inp_sh[0] ? 2'h2 : 2'h1))
        else $error("negative route wrong");
    core_enable_a: assert property (analog_ctrl.core_enable == main_sh[7])
        else $error("core enable wrong");
    speed_mode_a: assert property (analog_ctrl.speed_power_select == main_sh[2])
        else $error("speed select wrong");
    hyst_out_a: assert property (analog_ctrl.hysteresis_enable == main_sh[1])
        else $error("hysteresis wrong");
    pin_drive_a: assert property (pin_oe == (main_sh[5] && !dir2_sh))
        else $error("pin enable wrong");
    flag_hold_a: assert property (
        cmp_irq_flag && !(reg_wr && reg_addr == `CMPCTL_ADDR_FLAG && !reg_wdata[0]) |=> cmp_irq_flag)
        else $error("flag dropped without clear");
    result_path_a: assert property (
        main_sh[7] && !main_sh[3] && $past(main_sh) == main_sh && $past(main_sh, 2) == main_sh
        && !$past(rst) && !$past(rst, 2)
        |-> consumer_out.waveform_shutdown == ($past(cmp_raw, 2) ^ main_sh[4]))
        else $error("shutdown output wrong");
    sync_gate_a: assert property (
        main_sh[0] && $past(main_sh[0]) && !$past(rst) && $changed(consumer_out.timer_gate)
        |-> $past(timer_clk_src, 2) && !$past(timer_clk_src))
        else $error("timer output moved off a timer fall");
    filter_hold_a: assert property (
        main_sh[3] && main_sh[7] && $stable(main_sh) && $changed(consumer_out.waveform_shutdown)
        |=> consumer_out.waveform_shutdown == $past(consumer_out.waveform_shutdown)
        || !$stable(main_sh))
        else $error("filter let a reversal through");
endmodule

bind cmpctl_top cmpctl_checker i_cmpctl_checker (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .cmp_raw(cmp_raw), .analog_ctrl(analog_ctrl),
    .timer_clk_src(timer_clk_src), .consumer_out(consumer_out), .pin_oe(pin_oe),
    .cmp_irq_flag(cmp_irq_flag));

// ===== tb/comparator_control_logic_tb.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: read data one cycle after the strobe
// Notes:   result settles within a fixed wait of fourteen cycles
`timescale 1ns/1ps
module comparator_control_logic_tb
    import cmpctl_pkg::*;
;
    logic             core_clk = 1'b0, rst = 1'b1, tclk = 1'b0, slow = 1'b0;
    logic             reg_wr = 1'b0, reg_rd = 1'b0, res_m = 1'b0, flag_m = 1'b0;
    logic             cmp_raw, pin_out, pin_oe, cmp_irq_flag;
    logic [3:0]       reg_addr = 4'h0;
    logic [7:0]       reg_wdata = 8'h00, reg_rdata, main_m = 8'h04, inp_m = 8'h00;
    logic [7:0]       vp_pin = 8'h00, v_dac = 8'h00, v_fvr = 8'h00, v_n0 = 8'h01, v_n1 = 8'h01;
    logic [5:0]       pins = 6'h00, sel;
    cmpctl_analog_s   actl;
    cmpctl_consumer_s cons;
    int               bad_count = 0, tests_run = 0;

    always #5 core_clk = ~core_clk;
    always #70 tclk = ~tclk;

    cmpctl_top i_cmpctl_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_raw(cmp_raw), .analog_ctrl(actl), .timer_clk_src(tclk), .consumer_out(cons),
        .port_pins_in(pins), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_irq_flag(cmp_irq_flag));
    cmpctl_core_model i_cmpctl_core_model (.core_clk(core_clk), .analog_ctrl(actl),
        .slow(slow), .v_pin(vp_pin), .v_dac(v_dac), .v_fvr(v_fvr), .v_n0(v_n0),
        .v_n1(v_n1), .cmp_raw(cmp_raw));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        case (a)
            4'h0: main_m = d & 8'hbf;
            4'h1: inp_m = d & 8'hf1;
            4'h2: if (!d[0]) flag_m = 1'b0;
            default: ;
        endcase
    endtask

    task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask

    function automatic logic exp_res();
        logic [7:0] vp;
        vp = inp_m[5] ? (inp_m[4] ? 8'h00 : v_fvr) : (inp_m[4] ? v_dac : vp_pin);
        return (main_m[7] & (vp > (inp_m[0] ? v_n1 : v_n0))) ^ main_m[4];
    endfunction

    // positives even, negatives odd: never equal
    task automatic setv();
        @(posedge core_clk);
        vp_pin <= 8'($urandom) & 8'hfe;
        v_dac <= 8'($urandom) & 8'hfe;
        v_fvr <= 8'($urandom) & 8'hfe;
        v_n0 <= 8'($urandom) | 8'h01;
        v_n1 <= 8'($urandom) | 8'h01;
    endtask

    task automatic step();
        logic r;
        repeat (14) @(posedge core_clk);
        #1;
        r = exp_res();
        if ((r && !res_m && inp_m[7]) || (!r && res_m && inp_m[6])) flag_m = 1'b1;
        res_m = r;
        chk("shutdown", {7'h0, r}, {7'h0, cons.waveform_shutdown});
        chk("mirror_out", {7'h0, r}, {7'h0, cons.result_mirror});
        chk("flag_pin", {7'h0, flag_m}, {7'h0, cmp_irq_flag});
        rdc("main", 4'h0, {main_m[7], r, main_m[5:0]});
        rdc("mirror", 4'h3, {7'h0, r});
        rdc("flag", 4'h2, {7'h0, flag_m});
    endtask

    initial begin
        void'($urandom(10642));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rdc("main_rst", 4'h0, 8'h04);
        rdc("inputs_rst", 4'h1, 8'h00);
        rdc("unmapped", 4'hf, 8'h00);
        // disabled core: polarity flip alone makes a rising edge
        wr(4'h1, 8'h80);
        step();
        wr(4'h0, 8'h14);
        step();
        wr(4'h2, 8'h01);
        step();
        wr(4'h2, 8'h00);
        step();
        // core on with edges masked: its first samples are unsettled
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h84);
        step();
        for (int i = 0; i < 16; i++) begin
            wr(4'h2, 8'h00);
            slow <= i[3];
            setv();
            step();
            wr(4'h1, {2'($urandom), i[1:0], 3'h0, i[2]});
            step();
            wr(4'h0, {3'h4, 1'($urandom), 1'h0, ~i[3], i[0], 1'h0});
            step();
        end
        slow <= 1'b0;
        // filter on, input chatters every cycle
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h8c);
        v_n0 <= 8'h81;
        step();
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            vp_pin <= k[0] ? 8'hff : 8'h00;
        end
        step();
        // pin drive without enable, synced to timer falls
        wr(4'h6, 8'h3b);
        wr(4'h0, 8'h35);
        step();
        repeat (16) @(posedge core_clk);
        #1 chk("pin_oe", 8'h01, {7'h0, pin_oe});
        chk("pin_out", 8'h01, {7'h0, pin_out});
        // polarity flip: pin keeps its level until a timer fall
        wr(4'h0, 8'h25);
        #1 chk("pin_hold", 8'h01, {7'h0, pin_out});
        repeat (16) @(posedge core_clk);
        #1 chk("pin_sync", 8'h00, {7'h0, pin_out});
        for (int k = 0; k < 4; k++) begin
            sel = 6'($urandom);
            wr(4'h5, {2'h0, sel});
            @(posedge core_clk);
            pins <= 6'($urandom);
            #1 rdc("port", 4'h4, {2'h0, pins & ~sel});
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop();
    end
endmodule
